/* core/tfc_pkg.sv */
// package: register map, field positions, reset values and frame counts of the transmit framer
// Operation
// - E1 spare registers give Sa6/Sa7/Sa8 for odd frames; bit 7 is frame 15.
// - framer off keeps the port quiet; after init done and enable it runs.
// - soft restart holds the port in reset while high; registers keep their contents.
// - line standard bit picks T1 (0) or E1 (1) for the transmitter only.
// - Japanese CRC-6 select also folds the F bits into the CRC-6.
// - F-bit pass-through takes F bits from serial input; CRC pass-through takes CRC-6.
// - software signaling needs bit-7 stuffing enable and uses the channel select mask.
// - global stuffing stuffs every all-zero channel not given the DDS code; else the channel select mask decides.
// - zero substitution: B8ZS in T1, HDB3 in E1, when enabled.
// - alarm indication sends unframed all ones on the line in both standards.
// - T1 remote alarm is sent only while its enable bit is set.
// - E1 time slot 0 comes from serial input on pass-through, else from registers.
// - E1 time slot 16 comes from signaling register when selected, else per channel.
// - E1 G.802 forces channel-block output high at bit 1 of time slot 26.
// - E1 Si bits come from CRC-4 when enabled, else from align registers when selected, else from serial input.
// - E1 signaling all-ones forces time slot 16 to all ones in every frame.
// - E1 CRC-4 enable turns multiframe CRC-4 generation on.
// - T1 data link source: HDLC input when set, else FDL register or SLC formatter.
// - T1 SLC enable inserts the SLC pattern from the three SLC registers.
// - T1 DDS replaces all-zero selected channel bytes with 10011000.
// - periodic corruption hits one in 128 Ft/FPS bits; burst corrupts next three.
// - remote alarm type picks T1 or J1 alarm form, for D4 and ESF.
// - bit-7 stuffing enable forces bit 7 high in qualifying all-zero channels.
`default_nettype none
package tfc_pkg;
  localparam int NPORTS = 4;
  localparam logic [10:0] PORT_STRIDE = 11'h200;
  // local register indexes; byte address is four times index plus stride
  localparam logic [8:0] R_FDL = 9'h162;
  localparam logic [8:0] R_SLC1 = 9'h164;
  localparam logic [8:0] R_SLC2 = 9'h165;
  localparam logic [8:0] R_SLC3 = 9'h166;
  localparam logic [8:0] R_SA6 = 9'h16B;
  localparam logic [8:0] R_SA7 = 9'h16C;
  localparam logic [8:0] R_SA8 = 9'h16D;
  localparam logic [8:0] R_MMR = 9'h180;
  localparam logic [8:0] R_CR1 = 9'h181;
  localparam logic [8:0] R_CR2 = 9'h182;
  localparam logic [8:0] R_EXT = 9'h190;
  localparam logic [8:0] R_CSEL = 9'h191;
  localparam logic [8:0] R_DSEL = 9'h192;
  localparam logic [8:0] R_SIG = 9'h193;
  localparam logic [8:0] R_STAT = 9'h194;
  // master mode fields
  localparam int B_ON = 7;
  localparam int B_INIT = 6;
  localparam int B_SRST = 1;
  localparam int B_STD = 0;
  // control one, T1 reading
  localparam int B_JAPAN = 7;
  localparam int B_FPT = 6;
  localparam int B_CPT = 5;
  localparam int B_SSRC = 4;
  localparam int B_GB7 = 3;
  localparam int B_RAI = 0;
  // control one, E1 reading
  localparam int B_TS0PT = 7;
  localparam int B_TS16R = 6;
  localparam int B_G802 = 5;
  localparam int B_SIREG = 4;
  localparam int B_TS16ONES = 3;
  localparam int B_CRC4 = 0;
  // shared control one fields
  localparam int B_ZS = 2;
  localparam int B_AIS = 1;
  // control two fields; the D4 select bit sits in the extended register
  localparam int B_DLSRC = 7;
  localparam int B_SLC = 6;
  localparam int B_DDS = 5;
  localparam int B_FCP = 4;
  localparam int B_FCB = 3;
  localparam int B_RTYPE = 2;
  localparam int B_B7EN = 0;
  localparam int B_D4 = 0;
  // reset values
  localparam logic [7:0] RST_ALIGN = 8'h1B;
  localparam logic [7:0] RST_NALIGN = 8'h40;
  // frame geometry and codes
  localparam logic [7:0] T1_LAST_POS = 8'hC0;
  localparam logic [7:0] E1_LAST_POS = 8'hFF;
  localparam logic [4:0] D4_FRAMES = 5'h0C;
  localparam logic [4:0] ESF_FRAMES = 5'h18;
  localparam logic [4:0] E1_FRAMES = 5'h10;
  localparam logic [4:0] SLC_BITS = 5'h18;
  localparam logic [4:0] J1_RAI_FRAME = 5'h0B;
  localparam logic [4:0] TS16 = 5'h10;
  localparam logic [7:0] LINE_DELAY = 8'h08;
  localparam logic [7:0] G802_POS = 8'hD0 + LINE_DELAY;
  localparam logic [6:0] CORRUPT_LAST = 7'h7F;
  localparam logic [1:0] BURST_LEN = 2'h3;
  localparam logic [7:0] DDS_CODE = 8'h98;
  localparam logic [7:0] B7_MASK = 8'h02;
  localparam logic [5:0] SYNC_PATTERN = 6'h0B;
  localparam logic [5:0] CRC6_POLY = 6'h03;
  localparam logic [3:0] CRC4_POLY = 4'h3;
  // line coder symbols: zero, normal mark, violation
  localparam logic [15:0] B8ZS_PAT = 16'h0249;
  localparam logic [15:0] HDB3_ODD_PAT = 16'h0200;
  localparam logic [15:0] HDB3_EVEN_PAT = 16'h4200;
  localparam logic [3:0] B8ZS_LEN = 4'h8;
  localparam logic [3:0] HDB3_LEN = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* core/tfc_top.sv */
// four-port transmit framer control with AXI4-Lite register access
`default_nettype none
module tfc_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [12:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [12:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] tx_serial_in,
  input wire logic [3:0] hdlc_fdl_bit,
  output logic [3:0] line_out_pos,
  output logic [3:0] line_out_neg,
  output logic [3:0] tx_channel_block_out
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] fdl, slc1, slc2, slc3, sa6, sa7, sa8, mmr, cr1, cr2, ext, sig;
    logic [31:0] csel, dsel;
    logic run;
    logic [7:0] pos;
    logic [4:0] frm;
    logic [7:0] inb, outb;
    logic [5:0] crc6, crc6_l;
    logic [3:0] crc4, crc4_l;
    logic [6:0] fcnt;
    logic [1:0] burst;
    logic fcb_prev;
    logic [4:0] dl_idx;
    logic [7:0] win;
    logic [15:0] pat;
    logic [3:0] patn;
    logic pol, vpar;
  } tfc_port_s;

  typedef struct packed {
    tfc_port_s [tfc_pkg::NPORTS-1:0] pt;
    logic [3:0] s1, s2, lpos, lneg, blk;
    logic awr, wr, bv, arr, rv, aw_have, w_have;
    logic [1:0] br, rr;
    logic [12:0] awa;
    logic [31:0] wd, rd;
    logic [3:0] ws;
  } tfc_state_s;

  tfc_state_s st_q, st_d;

  function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // returns {mapped, data}
  function automatic logic [32:0] reg_read(input tfc_port_s p, input logic [8:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    unique case (a)
      tfc_pkg::R_FDL: r[7:0] = p.fdl;
      tfc_pkg::R_SLC1: r[7:0] = p.slc1;
      tfc_pkg::R_SLC2: r[7:0] = p.slc2;
      tfc_pkg::R_SLC3: r[7:0] = p.slc3;
      tfc_pkg::R_SA6: r[7:0] = p.sa6;
      tfc_pkg::R_SA7: r[7:0] = p.sa7;
      tfc_pkg::R_SA8: r[7:0] = p.sa8;
      tfc_pkg::R_MMR: r[7:0] = p.mmr;
      tfc_pkg::R_CR1: r[7:0] = p.cr1;
      tfc_pkg::R_CR2: r[7:0] = p.cr2;
      tfc_pkg::R_EXT: r[7:0] = p.ext;
      tfc_pkg::R_CSEL: r[31:0] = p.csel;
      tfc_pkg::R_DSEL: r[31:0] = p.dsel;
      tfc_pkg::R_SIG: r[7:0] = p.sig;
      tfc_pkg::R_STAT: r[13:0] = {p.run, p.frm, p.pos};
      default: r = {1'b0, 32'h0000_0000};
    endcase
    return r;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    tfc_port_s pn, pq;
    logic e1, d4, run, isf, ser, lb, lbx, eof, eomf, fbit, gen, dlbit, cor, ftfps;
    logic cb, fb, zero, wr_go, si, dl_used;
    logic [7:0] t, raw, ob, last_pos;
    logic [4:0] ch, nch, nfr, nfrm, nf;
    logic [2:0] bi;
    logic [1:0] sym, sidx;
    logic [23:0] slcv;
    logic [32:0] rdv;
    logic [10:0] wi, ri;
    pn = '0;
    pq = '0;
    {e1, d4, run, isf, ser, lb, lbx, eof, eomf, fbit, gen, dlbit, cor, ftfps} = '0;
    {cb, fb, zero, wr_go, si, dl_used} = '0;
    {t, raw, ob, last_pos, ch, nch, nfr, nfrm, nf, bi, sym, sidx, slcv} = '0;
    {rdv, wi, ri} = '0;
    st_d = st_q;
    // two-stage synchroniser on the backplane serial inputs
    st_d.s1 = tx_serial_in;
    st_d.s2 = st_q.s1;

    // ---------- register bus ----------
    wi = st_q.awa[12:2];
    ri = s_axi_araddr[12:2];
    if (s_axi_awvalid && st_q.awr) begin
      st_d.awa = s_axi_awaddr;
      st_d.aw_have = 1'b1;
      st_d.awr = 1'b0;
    end
    if (s_axi_wvalid && st_q.wr) begin
      st_d.wd = s_axi_wdata;
      st_d.ws = s_axi_wstrb;
      st_d.w_have = 1'b1;
      st_d.wr = 1'b0;
    end
    wr_go = st_q.aw_have && st_q.w_have && !st_q.bv;
    if (wr_go) begin
      rdv = reg_read(st_q.pt[wi[10:9]], wi[8:0]);
      st_d.bv = 1'b1;
      st_d.br = (rdv[32] && wi[8:0] != tfc_pkg::R_STAT) ? tfc_pkg::RESP_OKAY
                                                         : tfc_pkg::RESP_SLVERR;
      st_d.aw_have = 1'b0;
      st_d.w_have = 1'b0;
    end
    if (st_q.bv && s_axi_bready) begin
      st_d.bv = 1'b0;
      st_d.awr = 1'b1;
      st_d.wr = 1'b1;
    end
    rdv = reg_read(st_q.pt[ri[10:9]], ri[8:0]);
    if (s_axi_arvalid && st_q.arr) begin
      st_d.arr = 1'b0;
      st_d.rv = 1'b1;
      st_d.rd = rdv[31:0];
      st_d.rr = rdv[32] ? tfc_pkg::RESP_OKAY : tfc_pkg::RESP_SLVERR;
    end
    if (st_q.rv && s_axi_rready) begin
      st_d.rv = 1'b0;
      st_d.arr = 1'b1;
    end

    // ---------- per-port framer, each port fully independent ----------
    for (int p = 0; p < tfc_pkg::NPORTS; p++) begin
      pq = st_q.pt[p];
      pn = pq;
      e1 = pq.mmr[tfc_pkg::B_STD];
      d4 = pq.ext[tfc_pkg::B_D4];
      run = pq.mmr[tfc_pkg::B_INIT] && pq.mmr[tfc_pkg::B_ON] && !pq.mmr[tfc_pkg::B_SRST];
      pn.run = run;
      ser = st_q.s2[p];
      t = e1 ? pq.pos : pq.pos - 8'h01;
      isf = !e1 && pq.pos == 8'h00;
      ch = t[7:3];
      bi = t[2:0];
      nfr = e1 ? tfc_pkg::E1_FRAMES : (d4 ? tfc_pkg::D4_FRAMES : tfc_pkg::ESF_FRAMES);
      last_pos = e1 ? tfc_pkg::E1_LAST_POS : tfc_pkg::T1_LAST_POS;
      eof = pq.pos == last_pos;
      eomf = eof && pq.frm == nfr - 5'h01;
      nfrm = eomf ? 5'h00 : pq.frm + 5'h01;
      slcv = {pq.slc3, pq.slc2, pq.slc1};
      // ---- T1 F bit ----
      dlbit = pq.cr2[tfc_pkg::B_DLSRC] ? hdlc_fdl_bit[p]
            : (pq.cr2[tfc_pkg::B_SLC] ? slcv[pq.dl_idx] : pq.fdl[pq.dl_idx[2:0]]);
      if (d4) begin
        ftfps = !pq.frm[0];
        dl_used = pq.frm[0];
        if (!pq.frm[0]) begin
          gen = !pq.frm[1];
        end else if (pq.cr1[tfc_pkg::B_RAI] && pq.cr2[tfc_pkg::B_RTYPE]
                     && pq.frm == tfc_pkg::J1_RAI_FRAME) begin
          gen = 1'b1;
        end else begin
          gen = dlbit;
        end
      end else begin
        ftfps = pq.frm[1:0] == 2'b11;
        dl_used = !pq.frm[0];
        unique case (pq.frm[1:0])
          2'b11: gen = tfc_pkg::SYNC_PATTERN[3'd5 - pq.frm[4:2]];
          2'b01: gen = pq.cr1[tfc_pkg::B_CPT] ? ser : pq.crc6_l[3'd5 - pq.frm[4:2]];
          default: begin
            if (pq.cr1[tfc_pkg::B_RAI]) begin
              gen = pq.cr2[tfc_pkg::B_RTYPE] ? 1'b1 : pq.dl_idx[3];
            end else begin
              gen = dlbit;
            end
          end
        endcase
      end
      cor = ftfps && ((pq.cr2[tfc_pkg::B_FCP] && pq.fcnt == tfc_pkg::CORRUPT_LAST)
                      || pq.burst != 2'h0);
      fbit = pq.cr1[tfc_pkg::B_FPT] ? ser : gen ^ cor;
      if (isf && ftfps) begin
        pn.fcnt = pq.fcnt + 7'h01;
        if (pq.burst != 2'h0) begin
          pn.burst = pq.burst - 2'h1;
        end
      end
      pn.fcb_prev = pq.cr2[tfc_pkg::B_FCB];
      if (pq.cr2[tfc_pkg::B_FCB] && !pq.fcb_prev) begin
        pn.burst = tfc_pkg::BURST_LEN;
      end
      if (isf && dl_used) begin
        pn.dl_idx = (pq.cr2[tfc_pkg::B_SLC] && pq.dl_idx == tfc_pkg::SLC_BITS - 5'h01)
                    ? 5'h00 : pq.dl_idx + 5'h01;
      end
      // ---- line bit and channel byte build ----
      lb = isf ? fbit : pq.outb[3'd7 - bi];
      lbx = pq.cr1[tfc_pkg::B_AIS] ? 1'b1 : lb;
      if (!isf) begin
        pn.inb = {pq.inb[6:0], ser};
      end
      if (!isf && bi == 3'h7) begin
        // serial data lead the line by one slot: the byte collected now goes out next slot
        raw = {pq.inb[6:0], ser};
        nch = (eof || (!e1 && ch == 5'h17)) ? 5'h00 : ch + 5'h01;
        nf = eof ? nfrm : pq.frm;
        zero = raw == 8'h00;
        ob = raw;
        if (e1) begin
          if (nch == 5'h00 && !pq.cr1[tfc_pkg::B_TS0PT]) begin
            if (!nf[0]) begin
              si = pq.cr1[tfc_pkg::B_CRC4] ? pq.crc4_l[2'd3 - nf[2:1]]
                 : (pq.cr1[tfc_pkg::B_SIREG] ? pq.slc1[7] : raw[7]);
              ob = {si, pq.slc1[6:0]};
            end else begin
              si = pq.cr1[tfc_pkg::B_CRC4]
                   ? (nf < 5'h0C ? tfc_pkg::SYNC_PATTERN[3'd5 - 3'(nf[4:1])] : 1'b1)
                   : (pq.cr1[tfc_pkg::B_SIREG] ? pq.slc2[7] : raw[7]);
              ob = {si, pq.slc2[6:3], pq.sa6[nf[3:1]], pq.sa7[nf[3:1]],
                    pq.sa8[nf[3:1]]};
            end
          end else if (nch == tfc_pkg::TS16) begin
            if (pq.cr1[tfc_pkg::B_TS16ONES]) begin
              ob = 8'hFF;
            end else if (pq.cr1[tfc_pkg::B_TS16R] || pq.csel[tfc_pkg::TS16]) begin
              ob = pq.sig;
            end
          end
        end else begin
          sidx = nf >= 5'h12 ? 2'h3 : (nf >= 5'h0C ? 2'h2 : (nf >= 5'h06 ? 2'h1 : 2'h0));
          if (pq.cr2[tfc_pkg::B_B7EN] && pq.cr1[tfc_pkg::B_SSRC] && pq.csel[nch]
              && (nf == 5'h05 || nf == 5'h0B || nf == 5'h11 || nf == 5'h17)) begin
            ob[0] = pq.sig[sidx];
          end
          if (pq.cr2[tfc_pkg::B_DDS] && pq.dsel[nch] && zero) begin
            ob = tfc_pkg::DDS_CODE;
          end else if (pq.cr2[tfc_pkg::B_B7EN] && zero
                       && (pq.cr1[tfc_pkg::B_GB7] || pq.csel[nch])) begin
            ob = tfc_pkg::B7_MASK;
          end
          if (pq.cr1[tfc_pkg::B_RAI] && d4 && !pq.cr2[tfc_pkg::B_RTYPE]) begin
            ob[6] = 1'b0;
          end
        end
        pn.outb = ob;
      end
      // ---- CRC-6 over the ESF multiframe, CRC-4 over each sub-multiframe ----
      if (!e1) begin
        cb = isf ? (pq.cr1[tfc_pkg::B_JAPAN] ? fbit : 1'b1) : lb;
        fb = pq.crc6[5] ^ cb;
        pn.crc6 = {pq.crc6[4:0], 1'b0} ^ (fb ? tfc_pkg::CRC6_POLY : 6'h00);
        if (eomf) begin
          pn.crc6_l = pn.crc6;
          pn.crc6 = 6'h00;
        end
      end else begin
        cb = (pq.pos == 8'h00 && !pq.frm[0]) ? 1'b0 : lb;
        fb = pq.crc4[3] ^ cb;
        pn.crc4 = {pq.crc4[2:0], 1'b0} ^ (fb ? tfc_pkg::CRC4_POLY : 4'h0);
        if (eof && pq.frm[2:0] == 3'h7) begin
          pn.crc4_l = pn.crc4;
          pn.crc4 = 4'h0;
        end
      end
      pn.pos = eof ? 8'h00 : pq.pos + 8'h01;
      if (eof) begin
        pn.frm = nfrm;
      end
      // ---- line coder: eight-bit look-ahead for zero substitution ----
      pn.win = {pq.win[6:0], lbx};
      if (pq.patn != 4'h0) begin
        sym = pq.pat[15:14];
        pn.pat = {pq.pat[13:0], 2'b00};
        pn.patn = pq.patn - 4'h1;
      end else if (pq.cr1[tfc_pkg::B_ZS] && e1 && pq.win[7:4] == 4'h0) begin
        pn.pat = pq.vpar ? tfc_pkg::HDB3_ODD_PAT : tfc_pkg::HDB3_EVEN_PAT;
        sym = pn.pat[15:14];
        pn.pat = {pn.pat[13:0], 2'b00};
        pn.patn = tfc_pkg::HDB3_LEN - 4'h1;
      end else if (pq.cr1[tfc_pkg::B_ZS] && !e1 && pq.win == 8'h00) begin
        sym = tfc_pkg::B8ZS_PAT[15:14];
        pn.pat = {tfc_pkg::B8ZS_PAT[13:0], 2'b00};
        pn.patn = tfc_pkg::B8ZS_LEN - 4'h1;
      end else begin
        sym = {1'b0, pq.win[7]};
      end
      st_d.lpos[p] = 1'b0;
      st_d.lneg[p] = 1'b0;
      if (sym == 2'h1) begin
        pn.pol = !pq.pol;
        pn.vpar = !pq.vpar;
        st_d.lpos[p] = !pq.pol;
        st_d.lneg[p] = pq.pol;
      end else if (sym == 2'h2) begin
        pn.vpar = 1'b0;
        st_d.lpos[p] = pq.pol;
        st_d.lneg[p] = !pq.pol;
      end
      st_d.blk[p] = e1 && pq.cr1[tfc_pkg::B_G802] && pq.pos == tfc_pkg::G802_POS;
      if (!run) begin
        // low-power hold: timing and coder cleared, configuration kept
        {pn.pos, pn.frm, pn.inb, pn.outb, pn.win, pn.pat} = '0;
        {pn.patn, pn.pol, pn.vpar, pn.crc6, pn.crc4, pn.fcnt, pn.dl_idx} = '0;
        st_d.lpos[p] = 1'b0;
        st_d.lneg[p] = 1'b0;
        st_d.blk[p] = 1'b0;
      end
      // ---- register writes: registers survive soft restart ----
      if (wr_go && wi[10:9] == 2'(p)) begin
        unique case (wi[8:0])
          tfc_pkg::R_FDL: if (st_q.ws[0]) pn.fdl = st_q.wd[7:0];
          tfc_pkg::R_SLC1: if (st_q.ws[0]) pn.slc1 = st_q.wd[7:0];
          tfc_pkg::R_SLC2: if (st_q.ws[0]) pn.slc2 = st_q.wd[7:0];
          tfc_pkg::R_SLC3: if (st_q.ws[0]) pn.slc3 = st_q.wd[7:0];
          tfc_pkg::R_SA6: if (st_q.ws[0]) pn.sa6 = st_q.wd[7:0];
          tfc_pkg::R_SA7: if (st_q.ws[0]) pn.sa7 = st_q.wd[7:0];
          tfc_pkg::R_SA8: if (st_q.ws[0]) pn.sa8 = st_q.wd[7:0];
          tfc_pkg::R_MMR: if (st_q.ws[0]) pn.mmr = st_q.wd[7:0];
          tfc_pkg::R_CR1: if (st_q.ws[0]) pn.cr1 = st_q.wd[7:0];
          tfc_pkg::R_CR2: if (st_q.ws[0]) pn.cr2 = st_q.wd[7:0];
          tfc_pkg::R_EXT: if (st_q.ws[0]) pn.ext = st_q.wd[7:0];
          tfc_pkg::R_CSEL: pn.csel = merge32(pq.csel, st_q.wd, st_q.ws);
          tfc_pkg::R_DSEL: pn.dsel = merge32(pq.dsel, st_q.wd, st_q.ws);
          tfc_pkg::R_SIG: if (st_q.ws[0]) pn.sig = st_q.wd[7:0];
          default: pn.fdl = pn.fdl;
        endcase
      end
      st_d.pt[p] = pn;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= '0;
      st_q.awr <= 1'b1;
      st_q.wr <= 1'b1;
      st_q.arr <= 1'b1;
      for (int i = 0; i < tfc_pkg::NPORTS; i++) begin
        st_q.pt[i].slc1 <= tfc_pkg::RST_ALIGN;
        st_q.pt[i].slc2 <= tfc_pkg::RST_NALIGN;
      end
    end else begin
      st_q <= st_d;
    end
  end

  assign s_axi_awready = st_q.awr;
  assign s_axi_wready = st_q.wr;
  assign s_axi_bvalid = st_q.bv;
  assign s_axi_bresp = st_q.br;
  assign s_axi_arready = st_q.arr;
  assign s_axi_rvalid = st_q.rv;
  assign s_axi_rdata = st_q.rd;
  assign s_axi_rresp = st_q.rr;
  assign line_out_pos = st_q.lpos;
  assign line_out_neg = st_q.lneg;
  assign tx_channel_block_out = st_q.blk;

  // ****************************************
  // checks on port 0 and the bus
  // ****************************************
  default clocking cb_chk @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_idle_quiet;
    // the line register is loaded in the same cycle that the run flag is, so compare them aligned
    !st_q.pt[0].run |-> !line_out_pos[0] && !line_out_neg[0];
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("line active while port held");

  property p_srst_hold;
    st_q.pt[0].mmr[tfc_pkg::B_SRST] |=> !st_q.pt[0].run && !line_out_pos[0] && !line_out_neg[0];
  endproperty
  a_srst_hold: assert property (p_srst_hold) else $error("port ran during soft restart");

  property p_srst_keeps;
    st_q.pt[0].mmr[tfc_pkg::B_SRST] && !st_q.aw_have |=> $stable(st_q.pt[0].cr1);
  endproperty
  a_srst_keeps: assert property (p_srst_keeps) else $error("soft restart changed register");

  property p_ais_ones;
    // the port must still run in the cycle checked, a soft restart may stop it at any time
    (st_q.pt[0].run && st_q.pt[0].cr1[tfc_pkg::B_AIS] && !st_q.pt[0].cr1[tfc_pkg::B_ZS])[*8]
      ##1 (st_q.pt[0].run && st_q.pt[0].cr1[tfc_pkg::B_AIS]) ##1 st_q.pt[0].run
      |-> line_out_pos[0] ^ line_out_neg[0];
  endproperty
  a_ais_ones: assert property (p_ais_ones) else $error("no mark during alarm indication");

  property p_g802;
    tx_channel_block_out[0] |-> $past(st_q.pt[0].pos) == tfc_pkg::G802_POS
                                && $past(st_q.pt[0].mmr[tfc_pkg::B_STD]);
  endproperty
  a_g802: assert property (p_g802) else $error("block output at wrong bit");

  property p_hdb3_limit;
    // a line symbol reflects the coder setting of the cycle before it
    (st_q.pt[0].run && $past(st_q.pt[0].mmr[tfc_pkg::B_STD]) && $past(st_q.pt[0].cr1[tfc_pkg::B_ZS])
     && !line_out_pos[0] && !line_out_neg[0])[*4] |-> 1'b0;
  endproperty
  a_hdb3_limit: assert property (p_hdb3_limit) else $error("four zeros with HDB3 on");

  property p_no_dual;
    !(line_out_pos[0] && line_out_neg[0]);
  endproperty
  a_no_dual: assert property (p_no_dual) else $error("both line outputs high");

  property p_burst;
    $rose(st_q.pt[0].cr2[tfc_pkg::B_FCB]) |=> st_q.pt[0].burst == tfc_pkg::BURST_LEN;
  endproperty
  a_burst: assert property (p_burst) else $error("burst corruption not armed");

  property p_bresp;
    st_q.aw_have && st_q.w_have && !st_q.bv
      |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write answer missing");

  property p_rresp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rresp: assert property (p_rresp) else $error("read answer missing");

endmodule
`default_nettype wire

/* verif/tfc_far_model.sv */
// far-side model: backplane serial source and line receiver
`default_nettype none
module tfc_far_model (
  input wire logic sys_clk,
  input wire logic rst,
  output logic [3:0] tx_serial_in,
  output logic [3:0] hdlc_fdl_bit,
  input wire logic [3:0] line_out_pos,
  input wire logic [3:0] line_out_neg,
  output logic bad_symbol_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // fresh bits every cycle, so stale backplane data never passes for valid
  always @(posedge sys_clk) begin
    if (rst) begin
      tx_serial_in <= 4'h0;
      hdlc_fdl_bit <= 4'h0;
      bad_symbol_q <= 1'b0;
    end else begin
      tx_serial_in <= 4'($urandom);
      hdlc_fdl_bit <= 4'($urandom);
      if (|(line_out_pos & line_out_neg)) begin
        bad_symbol_q <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* verif/tfc_top_tb.sv */
// self-checking bench of the four-port transmit framer control
`default_nettype none
module tfc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0;
  logic rready = 1'b0, awready, wready, bvalid, arready, rvalid, bad;
  logic [12:0] awaddr = 13'h0000, araddr = 13'h0000;
  logic [31:0] wdata = 32'h00000000, rdata;
  logic [1:0] bresp, rresp;
  logic [3:0] ser, fdl, lpos, lneg, blk;
  int err_total = 0, total_checks = 0;
  always #4 sys_clk = ~sys_clk;
  tfc_top tfc_top_i (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_serial_in(ser),
    .hdlc_fdl_bit(fdl), .line_out_pos(lpos), .line_out_neg(lneg), .tx_channel_block_out(blk));
  tfc_far_model tfc_far_model_i (.sys_clk(sys_clk), .rst(rst), .tx_serial_in(ser),
    .hdlc_fdl_bit(fdl), .line_out_pos(lpos), .line_out_neg(lneg), .bad_symbol_q(bad));
  // ****************
  // bus and check helpers
  // ****************
  function automatic logic [12:0] ad(input logic [1:0] p, input logic [8:0] i);
    return {p, i, 2'b00};
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", 32'(bresp), 32'(e));
  endtask
  task automatic rchk(input logic [12:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge sys_clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arv <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk("rdata", rdata, e);
    chk("rresp", 32'(rresp), 32'(er));
  endtask
  // all-ones alarm must alternate marks every bit; a stopped port stays silent
  task automatic watch(input int p, input logic ais);
    logic last;
    last = lpos[p];
    repeat (64) begin
      @(posedge sys_clk);
      if (ais) begin
        chk("ais_mark", 32'(lpos[p] ^ lneg[p]), 32'h00000001);
        chk("ais_alt", 32'(lpos[p] ^ last), 32'h00000001);
      end else chk("idle_line", 32'({lpos[p], lneg[p]}), 32'h00000000);
      last = lpos[p];
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge sys_clk);
    err_total++;
    tally_and_finish;
  end
  initial begin
    logic [31:0] v[4];
    int nb0, nb1, z, zmax;
    void'($urandom(43));
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rchk(ad(2'h0, tfc_pkg::R_SA6), 32'h00000000, tfc_pkg::RESP_OKAY);
    rchk(ad(2'h3, tfc_pkg::R_MMR), 32'h00000000, tfc_pkg::RESP_OKAY);
    rchk(ad(2'h0, 9'h100), 32'h00000000, tfc_pkg::RESP_SLVERR);
    wr(ad(2'h1, tfc_pkg::R_STAT), 32'h000000FF, tfc_pkg::RESP_SLVERR);
    for (int p = 0; p < 4; p++) begin
      v[p] = 32'($urandom) & 32'h000000FF;
      wr(ad(2'(p), tfc_pkg::R_SA8), v[p], tfc_pkg::RESP_OKAY);
    end
    for (int p = 0; p < 4; p++) rchk(ad(2'(p), tfc_pkg::R_SA8), v[p], tfc_pkg::RESP_OKAY);
    watch(0, 1'b0);
    wr(ad(2'h0, tfc_pkg::R_CR1), 32'h00000002, tfc_pkg::RESP_OKAY);
    wr(ad(2'h0, tfc_pkg::R_MMR), 32'h00000081, tfc_pkg::RESP_OKAY);
    wr(ad(2'h0, tfc_pkg::R_MMR), 32'h000000C1, tfc_pkg::RESP_OKAY);
    wr(ad(2'h1, tfc_pkg::R_CR1), 32'h00000002, tfc_pkg::RESP_OKAY);
    wr(ad(2'h1, tfc_pkg::R_MMR), 32'h000000C0, tfc_pkg::RESP_OKAY);
    repeat (20) @(posedge sys_clk);
    watch(0, 1'b1);
    watch(1, 1'b1);
    watch(2, 1'b0);
    wr(ad(2'h0, tfc_pkg::R_MMR), 32'h000000C3, tfc_pkg::RESP_OKAY);
    repeat (12) @(posedge sys_clk);
    watch(0, 1'b0);
    rchk(ad(2'h0, tfc_pkg::R_MMR), 32'h000000C3, tfc_pkg::RESP_OKAY);
    rchk(ad(2'h0, tfc_pkg::R_CR1), 32'h00000002, tfc_pkg::RESP_OKAY);
    wr(ad(2'h0, tfc_pkg::R_MMR), 32'h000000C1, tfc_pkg::RESP_OKAY);
    repeat (20) @(posedge sys_clk);
    watch(0, 1'b1);
    wr(ad(2'h0, tfc_pkg::R_CR2), 32'h00000008, tfc_pkg::RESP_OKAY);
    wr(ad(2'h0, tfc_pkg::R_CR1), 32'h00000024, tfc_pkg::RESP_OKAY);
    nb0 = 0;
    nb1 = 0;
    z = 0;
    zmax = 0;
    // two whole E1 frames: one block pulse each, and HDB3 never lets four zeros through
    repeat (512) begin
      @(posedge sys_clk);
      nb0 += int'(blk[0]);
      nb1 += int'(blk[1]);
      z = (lpos[0] || lneg[0]) ? 0 : z + 1;
      if (z > zmax) zmax = z;
    end
    chk("g802_pulses", 32'(nb0), 32'h00000002);
    chk("t1_block", 32'(nb1), 32'h00000000);
    chk("hdb3_zero_run", 32'(zmax > 3), 32'h00000000);
    chk("bad_symbol", 32'(bad), 32'h00000000);
    tally_and_finish;
  end
endmodule
`default_nettype wire
